// *** irq_time_base_regs.vh ***
// register offsets, field positions, reset values and counts
`ifndef IRQ_TIME_BASE_REGS_VH
`define IRQ_TIME_BASE_REGS_VH

// byte offsets on the register bus
`define ADDR_W 5
`define TBCTL_OFS 5'h00
`define IRQ_CTL_OFS 5'h04
`define IRQ_FLAG_OFS 5'h08
`define EDGE_SEL_OFS 5'h0C
`define STATUS_OFS 5'h10

// time_base_control fields
`define TBCTL_RUN_BIT 7
`define TBCTL_CKSEL_BIT 6
`define TBCTL_R1_LSB 4
`define TBCTL_LP_BIT 3
`define TBCTL_R0_LSB 0
`define TBCTL_RST 8'h37

// irq control: enable bit 0, per-source enables above it
`define IRQ_GIE_BIT 0
`define IRQ_EN_LSB 1
`define IRQ_CTL_RST 9'h000

// source index, equal to flag bit and vector number
`define NUM_SRC 8
`define SRC_EXT0 3'h0
`define SRC_EXT1 3'h1
`define SRC_GRP0 3'h2
`define SRC_CONV 3'h5
`define SRC_TICK0 3'h6
`define SRC_TICK1 3'h7

// edge select codes, two bits per pin
`define EDGE_OFF 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
`define EDGE_SEL_RST 4'h0

// time base counts
`define TB_PRESCALE_LAST 2'h3
`define TICK0_BASE_LOG2 4'h8
`define TICK1_BASE_LOG2 4'hC
`define TB_CNT_W 15

`endif

// *** pin_edge_detect.v ***
// edge detector for the external interrupt pins
`timescale 1ns/1ps
`include "irq_time_base_regs.vh"
`default_nettype none
module pin_edge_detect #(
    parameter N = 2
) (
    input wire core_clk,
    input wire sys_rst,
    input wire clk_en,
    input wire [N-1:0] ext_irq_pins,
    input wire [2*N-1:0] edge_select_setting,
    input wire [N-1:0] ext_irq_enables,
    output wire [N-1:0] edge_hit
);
    reg [N-1:0] pin_prev_r;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            pin_prev_r <= {N{1'b0}};
        end else if (clk_en) begin
            pin_prev_r <= ext_irq_pins;
        end
    end

    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_pin
            wire [1:0] sel = edge_select_setting[2*i+1:2*i];
            wire rise = ext_irq_pins[i] & ~pin_prev_r[i];
            wire fall = ~ext_irq_pins[i] & pin_prev_r[i];
            // pin only serves as interrupt input while enabled
            assign edge_hit[i] = ext_irq_enables[i] & clk_en &
                (((sel == `EDGE_RISE) & rise) |
                 ((sel == `EDGE_FALL) & fall) |
                 ((sel == `EDGE_BOTH) & (rise | fall)));
        end
    endgenerate
endmodule
`default_nettype wire

// *** tick_divider.v ***
// time-base prescaler and divider with two overflow taps
`timescale 1ns/1ps
`include "irq_time_base_regs.vh"
`default_nettype none
module tick_divider #(
    parameter CNT_W = `TB_CNT_W
) (
    input wire core_clk,
    input wire sys_rst,
    input wire clk_en,
    input wire tick_run,
    input wire tick_clock_select,
    input wire sub_clk_tick,
    input wire [2:0] tick0_ratio,
    input wire [1:0] tick1_ratio,
    output reg tick0_ovf_r,
    output reg tick1_ovf_r,
    output reg [CNT_W-1:0] count_r
);
    reg [1:0] pre_r;
    wire tb_tick;
    wire [3:0] k0;
    wire [3:0] k1;

    // true when the low k bits of c are all ones
    function ones_below;
        input [CNT_W-1:0] c;
        input [3:0] k;
        integer i;
        begin
            ones_below = 1'b1;
            for (i = 0; i < CNT_W; i = i + 1) begin
                if ((i < k) && !c[i]) begin
                    ones_below = 1'b0;
                end
            end
        end
    endfunction

    // sub-clock or system clock / 4
    assign tb_tick = tick_clock_select ? (pre_r == `TB_PRESCALE_LAST)
                                       : sub_clk_tick;
    assign k0 = `TICK0_BASE_LOG2 + {1'b0, tick0_ratio};
    assign k1 = `TICK1_BASE_LOG2 + {2'b00, tick1_ratio};

    always @(posedge core_clk) begin
        if (sys_rst) begin
            pre_r <= 2'h0;
            count_r <= {CNT_W{1'b0}};
            tick0_ovf_r <= 1'b0;
            tick1_ovf_r <= 1'b0;
        end else if (clk_en) begin
            pre_r <= pre_r + 2'h1;
            // stopped divider restarts from zero, giving a full period
            if (!tick_run) begin
                count_r <= {CNT_W{1'b0}};
                tick0_ovf_r <= 1'b0;
                tick1_ovf_r <= 1'b0;
            end else begin
                if (tb_tick) begin
                    count_r <= count_r + {{(CNT_W-1){1'b0}}, 1'b1};
                end
                tick0_ovf_r <= tb_tick & ones_below(count_r, k0);
                tick1_ovf_r <= tb_tick & ones_below(count_r, k1);
            end
        end
    end
endmodule
`default_nettype wire

// *** irq_time_base.v ***
// interrupt request logic with time base and register slave
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "irq_time_base_regs.vh"
`default_nettype none

// Behaviour
// - pin flag set on selected edge
// - pin vector needs global and pin enable
// - edge select rising, falling, both or off
// - pin interrupt only while its enable set
// - servicing pin clears its flag and global enable
// - pull-high choice stays active in interrupt use
// - group flag set by any member flag
// - group vector needs enable, stack not full
// - service clears group flag only, members stay
// - converter flag set at conversion end
// - converter vector gated; service clears flag, global
// - tick flags set on divider overflow
// - tick vector gated; service clears flag, global
// - divider with two and three-bit ratio fields
// - clock select: sub-clock or system over four
// - any flag rising wakes the device
// - return-from-interrupt sets global enable again
// - no vector while global enable low
module irq_time_base #(
    parameter NUM_PINS = 2,
    parameter NUM_GRP = 3,
    parameter GRP_MEMBERS = 4
) (
    input wire core_clk,
    input wire sys_rst,
    input wire clk_en,
    // register bus
    input wire [`ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // event sources
    input wire [NUM_PINS-1:0] ext_irq_pins,
    input wire [NUM_PINS-1:0] pin_pull_high_select,
    input wire [NUM_GRP*GRP_MEMBERS-1:0] group_member_flags,
    input wire conv_done,
    input wire sub_clk_tick,
    // sequencer
    input wire stack_full,
    input wire irq_take,
    input wire return_from_irq_instruction,
    output reg irq_request_r,
    output reg [2:0] irq_vector_r,
    output reg wake_up_r,
    output reg [NUM_PINS-1:0] pin_pull_high_r,
    output reg slow_crystal_low_power_r
);
    // ************************************************************
    // state
    // ************************************************************
    reg [7:0] time_base_control_r;
    reg [7:0] time_base_control_nxt;
    reg global_irq_enable_r;
    reg global_irq_enable_nxt;
    reg [`NUM_SRC-1:0] src_enable_r;
    reg [`NUM_SRC-1:0] src_enable_nxt;
    reg [`NUM_SRC-1:0] flags_r;
    reg [`NUM_SRC-1:0] flags_nxt;
    reg [2*NUM_PINS-1:0] edge_sel_r;
    reg [2*NUM_PINS-1:0] edge_sel_nxt;
    reg [NUM_GRP*GRP_MEMBERS-1:0] member_prev_r;
    reg ack_r;
    reg [31:0] rdata_nxt;
    reg [31:0] wr_merged;

    wire bus_req;
    wire bus_done;
    wire wr_en;
    wire [NUM_PINS-1:0] edge_hit;
    wire tick0_ovf;
    wire tick1_ovf;
    wire [`TB_CNT_W-1:0] tb_count;
    wire [NUM_GRP-1:0] group_hit;
    wire [`NUM_SRC-1:0] hw_set;
    wire [`NUM_SRC-1:0] pending;
    wire take_ok;

    // ************************************************************
    // helpers
    // ************************************************************
    // byte-lane merge for a register write
    function [31:0] merge_bytes;
        input [31:0] old;
        input [31:0] wdata;
        input [3:0] be;
        integer b;
        begin
            merge_bytes = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (be[b]) begin
                    merge_bytes[8*b +: 8] = wdata[8*b +: 8];
                end
            end
        end
    endfunction

    // lowest index wins among pending sources
    function [2:0] first_set;
        input [`NUM_SRC-1:0] v;
        integer j;
        begin
            first_set = 3'h0;
            for (j = `NUM_SRC - 1; j >= 0; j = j - 1) begin
                if (v[j]) begin
                    first_set = j[2:0];
                end
            end
        end
    endfunction

    // ************************************************************
    // bus slave: one wait cycle on every access
    // ************************************************************
    assign bus_req = avs_read | avs_write;
    // a frozen clock must not let the master see the answer early
    assign avs_waitrequest = bus_req & ~(ack_r & clk_en);
    assign bus_done = bus_req & ack_r & clk_en;
    assign wr_en = avs_write & bus_done;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else if (clk_en) begin
            ack_r <= bus_req & ~ack_r;
            // captured in the wait cycle, stands at the accepting edge
            if (avs_read & ~ack_r) begin
                avs_readdata <= rdata_nxt;
            end
        end
    end

    always @* begin
        rdata_nxt = 32'h00000000;
        case (avs_address)
            `TBCTL_OFS: begin
                rdata_nxt[7:0] = time_base_control_r;
            end
            `IRQ_CTL_OFS: begin
                rdata_nxt[`IRQ_GIE_BIT] = global_irq_enable_r;
                rdata_nxt[`IRQ_EN_LSB +: `NUM_SRC] = src_enable_r;
            end
            `IRQ_FLAG_OFS: begin
                rdata_nxt[`NUM_SRC-1:0] = flags_r;
            end
            `EDGE_SEL_OFS: begin
                rdata_nxt[2*NUM_PINS-1:0] = edge_sel_r;
            end
            `STATUS_OFS: begin
                rdata_nxt[0] = irq_request_r;
                rdata_nxt[3:1] = irq_vector_r;
                rdata_nxt[4] = stack_full;
                rdata_nxt[16 +: `TB_CNT_W] = tb_count;
            end
            default: begin
                rdata_nxt = 32'h00000000;
            end
        endcase
    end

    // ************************************************************
    // event sources
    // ************************************************************
    pin_edge_detect #(
        .N(NUM_PINS)
    ) u_pins (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .ext_irq_pins(ext_irq_pins),
        .edge_select_setting(edge_sel_r),
        .ext_irq_enables(src_enable_r[NUM_PINS-1:0]),
        .edge_hit(edge_hit)
    );

    tick_divider #(
        .CNT_W(`TB_CNT_W)
    ) u_tick (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .tick_run(time_base_control_r[`TBCTL_RUN_BIT]),
        .tick_clock_select(time_base_control_r[`TBCTL_CKSEL_BIT]),
        .sub_clk_tick(sub_clk_tick),
        .tick0_ratio(time_base_control_r[`TBCTL_R0_LSB +: 3]),
        .tick1_ratio(time_base_control_r[`TBCTL_R1_LSB +: 2]),
        .tick0_ovf_r(tick0_ovf),
        .tick1_ovf_r(tick1_ovf),
        .count_r(tb_count)
    );

    // a member flag going high sets its group flag
    genvar g;
    generate
        for (g = 0; g < NUM_GRP; g = g + 1) begin : g_grp
            wire [GRP_MEMBERS-1:0] cur;
            wire [GRP_MEMBERS-1:0] prv;
            assign cur = group_member_flags[g*GRP_MEMBERS +: GRP_MEMBERS];
            assign prv = member_prev_r[g*GRP_MEMBERS +: GRP_MEMBERS];
            assign group_hit[g] = |(cur & ~prv);
        end
    endgenerate

    // member flags belong to their sources and are never cleared here
    always @(posedge core_clk) begin
        if (sys_rst) begin
            member_prev_r <= {(NUM_GRP*GRP_MEMBERS){1'b0}};
        end else if (clk_en) begin
            member_prev_r <= group_member_flags;
        end
    end

    assign hw_set = {tick1_ovf, tick0_ovf,
                     conv_done & clk_en,
                     group_hit & {NUM_GRP{clk_en}},
                     edge_hit};

    // ************************************************************
    // registers and flags
    // ************************************************************
    always @* begin
        time_base_control_nxt = time_base_control_r;
        global_irq_enable_nxt = global_irq_enable_r;
        src_enable_nxt = src_enable_r;
        flags_nxt = flags_r;
        edge_sel_nxt = edge_sel_r;
        wr_merged = 32'h00000000;
        if (wr_en) begin
            case (avs_address)
                `TBCTL_OFS: begin
                    wr_merged = merge_bytes({24'h000000, time_base_control_r},
                        avs_writedata, avs_byteenable);
                    time_base_control_nxt = wr_merged[7:0];
                end
                `IRQ_CTL_OFS: begin
                    wr_merged = merge_bytes({23'h000000, src_enable_r,
                        global_irq_enable_r}, avs_writedata, avs_byteenable);
                    {src_enable_nxt, global_irq_enable_nxt} = wr_merged[8:0];
                end
                `IRQ_FLAG_OFS: begin
                    // software may also set a flag, and a flag set this way raises a wake-up
                    wr_merged = merge_bytes({24'h000000, flags_r},
                        avs_writedata, avs_byteenable);
                    flags_nxt = wr_merged[7:0];
                end
                `EDGE_SEL_OFS: begin
                    wr_merged = merge_bytes(
                        {{(32-2*NUM_PINS){1'b0}}, edge_sel_r},
                        avs_writedata, avs_byteenable);
                    edge_sel_nxt = wr_merged[2*NUM_PINS-1:0];
                end
                default: begin
                    flags_nxt = flags_r;
                end
            endcase
        end
        // service: clear the taken flag and the global enable
        if (irq_take) begin
            flags_nxt[irq_vector_r] = 1'b0;
            global_irq_enable_nxt = 1'b0;
        end
        if (return_from_irq_instruction) begin
            global_irq_enable_nxt = 1'b1;
        end
        // new events win over any clear in the same cycle
        flags_nxt = flags_nxt | hw_set;
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            time_base_control_r <= `TBCTL_RST;
            {src_enable_r, global_irq_enable_r} <= `IRQ_CTL_RST;
            flags_r <= {`NUM_SRC{1'b0}};
            edge_sel_r <= {(2*NUM_PINS){1'b0}};
            wake_up_r <= 1'b0;
            pin_pull_high_r <= {NUM_PINS{1'b0}};
            slow_crystal_low_power_r <= 1'b0;
        end else if (clk_en) begin
            time_base_control_r <= time_base_control_nxt;
            global_irq_enable_r <= global_irq_enable_nxt;
            src_enable_r <= src_enable_nxt;
            flags_r <= flags_nxt;
            edge_sel_r <= edge_sel_nxt;
            // enables do not gate the wake-up
            wake_up_r <= |(flags_nxt & ~flags_r);
            // pull-high is never overridden by interrupt use
            pin_pull_high_r <= pin_pull_high_select;
            slow_crystal_low_power_r <=
                time_base_control_r[`TBCTL_LP_BIT];
        end
    end

    // ************************************************************
    // vector request to the sequencer
    // ************************************************************
    assign pending = flags_r & src_enable_r;
    assign take_ok = global_irq_enable_r & ~stack_full;

    // dropped in the cycle of a take so the same vector is not
    // offered twice before the global enable falls
    always @(posedge core_clk) begin
        if (sys_rst) begin
            irq_request_r <= 1'b0;
            irq_vector_r <= 3'h0;
        end else if (clk_en) begin
            irq_request_r <= take_ok & (|pending) & ~irq_take;
            if (|pending) begin
                irq_vector_r <= first_set(pending);
            end
        end
    end
endmodule
`default_nettype wire

// *** irq_time_base_properties.sv ***
// port-level checks for the interrupt and time-base block
`timescale 1ns/1ps
`default_nettype none
module irq_time_base_properties #(
    parameter NUM_PINS = 2
) (
    input wire core_clk,
    input wire sys_rst,
    input wire clk_en,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire [NUM_PINS-1:0] pin_pull_high_select,
    input wire stack_full,
    input wire irq_take,
    input wire return_from_irq_instruction,
    input wire irq_request_r,
    input wire [NUM_PINS-1:0] pin_pull_high_r,
    input wire slow_crystal_low_power_r
);
    // ************
    // enable mirror
    // ************
    logic gie_r;
    logic bus_ack;
    assign bus_ack = (avs_read | avs_write) & ~avs_waitrequest & clk_en;
    // return wins over take, as in the design
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            gie_r <= 1'b0;
        end else if (return_from_irq_instruction & clk_en) begin
            gie_r <= 1'b1;
        end else if (irq_take & clk_en) begin
            gie_r <= 1'b0;
        end else if (bus_ack & avs_write & (avs_address == 5'h04)
                     & avs_byteenable[0]) begin
            gie_r <= avs_writedata[0];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_wait_once: assert property ((avs_read | avs_write) && avs_waitrequest
        && clk_en |=> !avs_waitrequest) else $error("bus wait too long");
    a_wait_again: assert property (bus_ack |=> avs_waitrequest
        || !(avs_read | avs_write)) else $error("no wait after accept");
    a_read_hold: assert property (!(avs_read && avs_waitrequest)
        |=> $stable(avs_readdata)) else $error("read data moved");
    a_pull_copy: assert property (clk_en |=>
        pin_pull_high_r == $past(pin_pull_high_select))
        else $error("pull-high choice lost");
    a_lp_copy: assert property (bus_ack && avs_write
        && avs_address == 5'h00 && avs_byteenable[0]
        |-> ##2 (slow_crystal_low_power_r == $past(avs_writedata[3], 2)))
        else $error("low power bit not driven out");
    a_stack_gate: assert property (stack_full |=> !irq_request_r)
        else $error("request while stack full");
    a_gie_gate: assert property (!gie_r |=> !irq_request_r)
        else $error("request while global enable low");
    a_take_drop: assert property (irq_take
        && !return_from_irq_instruction |=> !irq_request_r)
        else $error("request held after take");
endmodule
bind irq_time_base irq_time_base_properties #(.NUM_PINS(NUM_PINS)) u_props (
    .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_pull_high_select(pin_pull_high_select), .stack_full(stack_full),
    .irq_take(irq_take),
    .return_from_irq_instruction(return_from_irq_instruction),
    .irq_request_r(irq_request_r), .pin_pull_high_r(pin_pull_high_r),
    .slow_crystal_low_power_r(slow_crystal_low_power_r)
);
`default_nettype wire

// *** seq_model.sv ***
// sequencer stand-in that takes vectors after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module seq_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic irq_request_r,
    input wire logic [2:0] irq_vector_r,
    input wire logic [1:0] take_delay,
    output logic irq_take,
    output logic [2:0] taken_vector
);
    // ************
    // take logic
    // ************
    logic [1:0] wait_r;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_take <= 1'b0;
            wait_r <= 2'h0;
            taken_vector <= 3'h0;
        end else if (irq_take) begin
            irq_take <= 1'b0;
            wait_r <= 2'h0;
        end else if (irq_request_r) begin
            // slow answers test that the request stays up meanwhile
            if (wait_r == take_delay) begin
                irq_take <= 1'b1;
                taken_vector <= irq_vector_r;
            end else begin
                wait_r <= wait_r + 2'h1;
            end
        end else begin
            wait_r <= 2'h0;
        end
    end
endmodule
`default_nettype wire

// *** irq_time_base_tb.sv ***
// self-checking bench for the interrupt and time-base block
`timescale 1ns/1ps
`include "irq_time_base_regs.vh"
`default_nettype none
module irq_time_base_tb;
    logic core_clk, sys_rst, clk_en, avs_read, avs_write, avs_waitrequest;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rdata;
    logic [3:0] avs_byteenable;
    logic [1:0] ext_irq_pins, pin_pull_high_select, pin_pull_high_r;
    logic [11:0] group_member_flags;
    logic conv_done, sub_clk_tick, sub_en, stack_full, irq_take, wake_up_r;
    logic return_from_irq_instruction, irq_request_r, slow_crystal_low_power_r;
    logic [2:0] irq_vector_r, taken_vector;
    logic [1:0] take_delay;
    int errors, num_checks, seed, n, i, g;
    irq_time_base u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_irq_pins(ext_irq_pins),
        .pin_pull_high_select(pin_pull_high_select),
        .group_member_flags(group_member_flags), .conv_done(conv_done),
        .sub_clk_tick(sub_clk_tick), .stack_full(stack_full),
        .irq_take(irq_take),
        .return_from_irq_instruction(return_from_irq_instruction),
        .irq_request_r(irq_request_r), .irq_vector_r(irq_vector_r),
        .wake_up_r(wake_up_r), .pin_pull_high_r(pin_pull_high_r),
        .slow_crystal_low_power_r(slow_crystal_low_power_r));
    seq_model u_seq (.core_clk(core_clk), .sys_rst(sys_rst),
        .irq_request_r(irq_request_r), .irq_vector_r(irq_vector_r),
        .take_delay(take_delay), .irq_take(irq_take),
        .taken_vector(taken_vector));
    // ************
    // clock, tasks and expectations
    // ************
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) sub_clk_tick <= sub_en & ~sub_clk_tick;
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        int k;
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (k == 20) begin
            chk(0, 1);
            close_out();
        end
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wait_req(input int lim);
        n = 0;
        while (irq_request_r !== 1'b1 && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        if (n == lim) begin
            chk(0, 1);
            close_out();
        end
    endtask
    function automatic logic exp_edge(input logic [1:0] c, input logic rise);
        return c == `EDGE_BOTH || (c == `EDGE_RISE && rise)
            || (c == `EDGE_FALL && !rise);
    endfunction
    function automatic int exp_period(input logic [7:0] c, input int src);
        int lg;
        lg = (src == 7) ? 12 + c[5:4] : 8 + c[2:0];
        return (c[6] ? 4 : 2) << lg;
    endfunction
    task automatic tick_test(input logic [7:0] c, input int src);
        int p;
        p = exp_period(c, src);
        bus(1'b1, `IRQ_FLAG_OFS, 32'h0);
        bus(1'b1, `IRQ_CTL_OFS, 32'h1 | (32'h2 << src));
        bus(1'b1, `TBCTL_OFS, {24'h0, c});
        wait_req(p + 40);
        chk(n >= p - 8 && n <= p + 8, 1);
        repeat (8) @(posedge core_clk);
        chk(taken_vector, src);
        bus(1'b1, `TBCTL_OFS, 32'h0);
    endtask
    initial begin
        seed = 32'hfd2f;
        errors = 0;
        num_checks = 0;
        {sys_rst, clk_en} = 2'h3;
        {avs_address, avs_read, avs_write, avs_writedata} = 0;
        avs_byteenable = 4'hF;
        {ext_irq_pins, pin_pull_high_select, group_member_flags} = 0;
        {conv_done, sub_en, stack_full} = 3'h0;
        return_from_irq_instruction = 1'b0;
        take_delay = 2'h0;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        bus(1'b0, `TBCTL_OFS, 32'h0);
        chk(rdata, `TBCTL_RST);
        bus(1'b0, `IRQ_CTL_OFS, 32'h0);
        chk(rdata, 32'h0);
        bus(1'b0, `EDGE_SEL_OFS, 32'h0);
        chk(rdata, 32'h0);
        bus(1'b1, 5'h14, 32'hFFFFFFFF);
        bus(1'b0, 5'h14, 32'h0);
        chk(rdata, 32'h0);
        bus(1'b1, `TBCTL_OFS, 32'h08);
        @(posedge core_clk);
        chk(slow_crystal_low_power_r, 1'b1);
        bus(1'b1, `IRQ_CTL_OFS, 32'h2);
        // bit3 picks the pin; pin1 stays disabled
        for (i = 0; i < 16; i++) begin
            ext_irq_pins <= i[0] ? 2'b00 : 2'b11;
            bus(1'b1, `EDGE_SEL_OFS, 32'(i[2:1]) << (2 * i[3]));
            bus(1'b1, `IRQ_FLAG_OFS, 32'h0);
            ext_irq_pins <= i[0] ? 2'b11 : 2'b00;
            repeat (3) @(posedge core_clk);
            bus(1'b0, `IRQ_FLAG_OFS, 32'h0);
            chk(rdata[i[3]], exp_edge(i[2:1], i[0]) & ~i[3]);
        end
        bus(1'b1, `EDGE_SEL_OFS, 32'h1);
        bus(1'b1, `IRQ_FLAG_OFS, 32'h0);
        bus(1'b1, `IRQ_CTL_OFS, 32'h3);
        ext_irq_pins <= 2'b00;
        @(posedge core_clk);
        ext_irq_pins <= 2'b11;
        wait_req(10);
        repeat (8) @(posedge core_clk);
        chk(taken_vector, 0);
        bus(1'b0, `IRQ_FLAG_OFS, 32'h0);
        chk(rdata[0], 1'b0);
        for (g = 0; g < 3; g++) begin
            take_delay <= 2'($random(seed));
            pin_pull_high_select <= 2'($random(seed));
            bus(1'b1, `IRQ_CTL_OFS, 32'h1 | (32'h8 << g));
            group_member_flags <= 12'h1 << (4 * g + {$random(seed)} % 4);
            wait_req(10);
            repeat (8) @(posedge core_clk);
            chk(taken_vector, g + 2);
            bus(1'b0, `IRQ_FLAG_OFS, 32'h0);
            chk(rdata[7:0], 8'h00);
            group_member_flags <= 12'h000;
        end
        stack_full <= 1'b1;
        bus(1'b1, `IRQ_CTL_OFS, 32'h41);
        conv_done <= 1'b1;
        @(posedge core_clk);
        conv_done <= 1'b0;
        n = 0;
        repeat (3) begin
            @(posedge core_clk);
            if (wake_up_r === 1'b1) n = 1;
        end
        chk(n, 1);
        repeat (10) @(posedge core_clk);
        chk(irq_request_r, 1'b0);
        stack_full <= 1'b0;
        wait_req(10);
        repeat (8) @(posedge core_clk);
        chk(taken_vector, `SRC_CONV);
        bus(1'b0, `IRQ_FLAG_OFS, 32'h0);
        chk(rdata[5], 1'b0);
        bus(1'b0, `IRQ_CTL_OFS, 32'h0);
        chk(rdata[0], 1'b0);
        return_from_irq_instruction <= 1'b1;
        @(posedge core_clk);
        return_from_irq_instruction <= 1'b0;
        bus(1'b0, `IRQ_CTL_OFS, 32'h0);
        chk(rdata[0], 1'b1);
        bus(1'b1, `IRQ_CTL_OFS, 32'h40);
        conv_done <= 1'b1;
        @(posedge core_clk);
        conv_done <= 1'b0;
        repeat (10) @(posedge core_clk);
        chk(irq_request_r, 1'b0);
        bus(1'b0, `IRQ_FLAG_OFS, 32'h0);
        chk(rdata[5], 1'b1);
        bus(1'b1, `IRQ_CTL_OFS, 32'h81);
        bus(1'b1, `TBCTL_OFS, 32'h40);
        n = 0;
        repeat (1500) begin
            @(posedge core_clk);
            if (irq_request_r !== 1'b0) n++;
        end
        chk(n, 0);
        tick_test(8'hC0, 6);
        tick_test(8'hC1, 6);
        sub_en <= 1'b1;
        tick_test(8'h80, 6);
        sub_en <= 1'b0;
        tick_test(8'hC0, 7);
        close_out();
    end
endmodule
`default_nettype wire
